// ### dcff_core.sv
// Top of the flag and mode FIFO: pointers, Gray crossing, flags and output modes.
// Assumes read_side_clock and write_side_clock are one-cycle enables on clock.
`timescale 1ns/1ps
module dcff_core
  import dcff_pkg::*;
#(
  parameter int port_word_size = DCFF_WORD_DEF,  // Allowed 4, 9, 18, 36, 72
  parameter int DEPTH          = DCFF_DEPTH_DEF
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     write_side_clock,
  input  wire logic                     read_side_clock,
  input  wire logic                     write_request,
  input  wire logic [port_word_size-1:0] write_data_in,
  input  wire logic                     read_request,
  input  wire logic                     lookahead_mode,
  input  wire logic                     single_clock_select,
  input  wire logic                     output_pipeline_select,
  input  wire logic [DCFF_THRESH_W-1:0] nearly_empty_threshold,
  input  wire logic [DCFF_THRESH_W-1:0] nearly_full_threshold,
  output logic [port_word_size-1:0]     read_data_out,
  output logic                          empty,
  output logic                          nearly_empty_flag,
  output logic                          read_underflow_flag,
  output logic                          full,
  output logic                          nearly_full_flag,
  output logic                          write_overflow_flag
);

  localparam int PW = $clog2(DEPTH) + 1;

  // Gray conversions for pointer crossing
  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
    end
    from_gray = b;
  endfunction

  // Write domain state
  logic [PW-1:0]   wbin_q, wbin_d;     // Write pointer
  logic [PW-1:0]   wgray_q, wgray_d;   // Its Gray copy
  logic [PW-1:0]   rg1_q, rg1_d;       // Read Gray, first stage
  logic [PW-1:0]   rg2_q, rg2_d;       // Read Gray, second stage
  dcff_wr_flags_t  wf_q, wf_d;         // Write-side flags

  // Read domain state
  logic [PW-1:0]   rbin_q, rbin_d;     // Read pointer
  logic [PW-1:0]   rgray_q, rgray_d;   // Its Gray copy
  logic [PW-1:0]   wg1_q, wg1_d;       // Write Gray, first stage
  logic [PW-1:0]   wg2_q, wg2_d;       // Write Gray, second stage
  logic            core_empty_q, core_empty_d; // Store empty as seen
  logic            look_valid_q, look_valid_d; // Lookahead word shown
  dcff_rd_flags_t  rf_q, rf_d;         // Read-side flags

  // Output data path
  logic [port_word_size-1:0] dout_q, dout_d;
  logic [port_word_size-1:0] stage_q, stage_d; // Captured store word for the pipeline
  logic            pend_q, pend_d;     // Store word arrives now
  logic            pipe_pend_q, pipe_pend_d; // Waiting for pipeline tick

  // Store handshake
  logic                      st_in_ready;
  logic                      st_out_valid;
  logic [port_word_size-1:0] st_out_data;
  logic                      wr_acc;
  logic                      rd_acc;
  logic                      fetch;
  logic                      pipe_on;

  // Write taken only on a tick, not full, store has room
  assign wr_acc  = write_side_clock & write_request & ~wf_q.full & st_in_ready;
  // User read taken only while empty is low
  assign rd_acc  = read_side_clock & read_request & ~rf_q.empty;
  // Pipeline register only exists in single-clock use
  assign pipe_on = single_clock_select & output_pipeline_select;

  // Store fetch: on the read in standard, on refill in lookahead
  always_comb begin
    if (lookahead_mode) begin
      fetch = read_side_clock & ~core_empty_q & (~look_valid_q | rd_acc);
    end else begin
      fetch = rd_acc & st_out_valid;
    end
  end

  // Write domain next values
  always_comb begin
    logic [PW-1:0]         rseen;
    logic [PW-1:0]         wcount;
    logic [DCFF_CMP_W-1:0] free_ext;
    rseen    = '0;
    wcount   = '0;
    free_ext = '0;
    wbin_d   = wbin_q;
    wgray_d  = wgray_q;
    rg1_d    = rg1_q;
    rg2_d    = rg2_q;
    wf_d     = wf_q;
    if (write_side_clock) begin
      if (wr_acc) begin
        wbin_d = wbin_q + 1'b1;
      end
      wgray_d = to_gray(wbin_d);
      rg1_d   = rgray_q;
      rg2_d   = rg1_q;
      // Same clock sees the live pointer, else the synchronised one
      rseen    = single_clock_select ? rbin_d : from_gray(rg2_q);
      wcount   = wbin_d - rseen;
      free_ext = DCFF_CMP_W'(PW'(DEPTH) - wcount);
      // Full rises with the filling write, clears after crossing, or on the read itself with single clock
      wf_d.full = (wcount == PW'(DEPTH));
      // Nearly-full with one step of hysteresis
      if (free_ext <= DCFF_CMP_W'(nearly_full_threshold)) begin
        wf_d.nearly_full = 1'b1;
      end else if (free_ext > DCFF_CMP_W'(nearly_full_threshold) + 1'b1) begin
        wf_d.nearly_full = 1'b0;
      end
      // Overflow stands while writes keep hitting full
      wf_d.overflow = write_request & wf_q.full;
    end
  end

  // Write domain registers
  always_ff @(posedge clock) begin
    if (rst) begin
      wbin_q  <= '0;
      wgray_q <= '0;
      rg1_q   <= '0;
      rg2_q   <= '0;
      wf_q    <= DCFF_WR_FLAGS_RST;
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= wgray_d;
      rg1_q   <= rg1_d;
      rg2_q   <= rg2_d;
      wf_q    <= wf_d;
    end
  end

  // Read domain next values
  always_comb begin
    logic [PW-1:0]         wseen;
    logic [PW-1:0]         rcount;
    logic [DCFF_CMP_W-1:0] cnt_ext;
    wseen        = '0;
    rcount       = '0;
    cnt_ext      = '0;
    rbin_d       = rbin_q;
    rgray_d      = rgray_q;
    wg1_d        = wg1_q;
    wg2_d        = wg2_q;
    core_empty_d = core_empty_q;
    look_valid_d = look_valid_q;
    rf_d         = rf_q;
    if (read_side_clock) begin
      // Pointer moves only on a fetch, so it freezes when empty
      if (fetch) begin
        rbin_d = rbin_q + 1'b1;
      end
      rgray_d = to_gray(rbin_d);
      wg1_d   = wgray_q;
      wg2_d   = wg1_q;
      wseen   = single_clock_select ? wbin_d : from_gray(wg2_q);
      rcount  = wseen - rbin_d;
      core_empty_d = (rcount == '0);
      // Shown word kept until read, refilled by a fetch
      if (lookahead_mode) begin
        if (fetch) begin
          look_valid_d = 1'b1;
        end else if (rd_acc) begin
          look_valid_d = 1'b0;
        end
        rf_d.empty = ~look_valid_d;
        cnt_ext    = DCFF_CMP_W'(rcount) + DCFF_CMP_W'(look_valid_d);
      end else begin
        look_valid_d = 1'b0;
        rf_d.empty   = core_empty_d;
        cnt_ext      = DCFF_CMP_W'(rcount);
      end
      // Nearly-empty with one step of hysteresis
      if (cnt_ext <= DCFF_CMP_W'(nearly_empty_threshold)) begin
        rf_d.nearly_empty = 1'b1;
      end else if (cnt_ext > DCFF_CMP_W'(nearly_empty_threshold) + 1'b1) begin
        rf_d.nearly_empty = 1'b0;
      end
      // Underflow stands while reads keep hitting empty
      rf_d.underflow = read_request & rf_q.empty;
    end
  end

  // Read domain registers
  always_ff @(posedge clock) begin
    if (rst) begin
      rbin_q       <= '0;
      rgray_q      <= '0;
      wg1_q        <= '0;
      wg2_q        <= '0;
      core_empty_q <= 1'b1;
      look_valid_q <= DCFF_VALID_RST;
      rf_q         <= DCFF_RD_FLAGS_RST;
    end else begin
      rbin_q       <= rbin_d;
      rgray_q      <= rgray_d;
      wg1_q        <= wg1_d;
      wg2_q        <= wg2_d;
      core_empty_q <= core_empty_d;
      look_valid_q <= look_valid_d;
      rf_q         <= rf_d;
    end
  end

  // Output word: direct, or through a stage register with the pipeline on
  always_comb begin
    dout_d      = dout_q;
    stage_d     = stage_q;
    pend_d      = fetch;
    pipe_pend_d = pipe_pend_q;
    // Capture the store word so a quick second read cannot overwrite it
    if (pend_q) begin
      stage_d = st_out_data;
    end
    if (pend_q && !pipe_on) begin
      dout_d = st_out_data;
    end
    // Pipeline: the captured word moves out on the next read tick
    if (pipe_pend_q && read_side_clock) begin
      dout_d      = stage_q;
      pipe_pend_d = 1'b0;
    end
    if (pend_q && pipe_on) begin
      pipe_pend_d = 1'b1;
    end
  end

  // Control of the output path resets; the word itself does not
  always_ff @(posedge clock) begin
    if (rst) begin
      pend_q      <= DCFF_VALID_RST;
      pipe_pend_q <= DCFF_VALID_RST;
    end else begin
      pend_q      <= pend_d;
      pipe_pend_q <= pipe_pend_d;
    end
  end

  // Data register left untouched by reset
  always_ff @(posedge clock) begin
    dout_q  <= dout_d;
    stage_q <= stage_d;
  end

  // DEPTH-word store in the data path, sixteen by default
  dcff_store #(
    .WIDTH (port_word_size),
    .DEPTH (DEPTH)
  ) u_store (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (wr_acc),
    .in_ready  (st_in_ready),
    .in_data   (write_data_in),
    .out_valid (st_out_valid),
    .out_ready (fetch),
    .out_data  (st_out_data)
  );

  // Ports straight from registers
  assign read_data_out       = dout_q;
  assign empty               = rf_q.empty;
  assign nearly_empty_flag   = rf_q.nearly_empty;
  assign read_underflow_flag = rf_q.underflow;
  assign full                = wf_q.full;
  assign nearly_full_flag    = wf_q.nearly_full;
  assign write_overflow_flag = wf_q.overflow;

endmodule

// ### dcff_monitor.sv
// Checker of the flag FIFO, watching the top module's ports only.
// Assumes one clock, tick enables per side and a synchronous reset.
`timescale 1ns/1ps
module dcff_monitor
  import dcff_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic write_side_clock,
  input wire logic read_side_clock,
  input wire logic write_request,
  input wire logic read_request,
  input wire logic lookahead_mode,
  input wire logic single_clock_select,
  input wire logic empty,
  input wire logic nearly_empty_flag,
  input wire logic read_underflow_flag,
  input wire logic full,
  input wire logic nearly_full_flag,
  input wire logic write_overflow_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Reset value of every flag
  a_reset_values: assert property (disable iff (1'b0) rst |=> empty && nearly_empty_flag && !full
    && !nearly_full_flag && !read_underflow_flag && !write_overflow_flag) else $error("reset flags wrong");
  // Error flags follow request and condition on each tick
  a_overflow_track: assert property (write_side_clock |=>
    write_overflow_flag == $past(write_request && full)) else $error("overflow flag wrong");
  a_underflow_track: assert property (read_side_clock |=>
    read_underflow_flag == $past(read_request && empty)) else $error("underflow flag wrong");
  // Flags move only on their own tick
  a_wr_flags_hold: assert property (!write_side_clock |=>
    $stable({full, nearly_full_flag, write_overflow_flag})) else $error("write flags moved");
  a_rd_flags_hold: assert property (!read_side_clock |=>
    $stable({empty, nearly_empty_flag, read_underflow_flag})) else $error("read flags moved");
  // Full and empty rise only through an access
  a_full_rise: assert property ($rose(full) |-> $past(write_side_clock && write_request))
    else $error("full rose without write");
  a_empty_rise: assert property ($rose(empty) |-> $past(read_side_clock && read_request))
    else $error("empty rose without read");
  // Nearly flags cover full, and empty outside lookahead
  a_full_near: assert property (full |-> nearly_full_flag) else $error("full without nearly full");
  a_empty_near: assert property (empty && !lookahead_mode |-> nearly_empty_flag)
    else $error("empty without nearly empty");
  // Single clock: a write clears empty at once
  a_sc_write_fast: assert property (single_clock_select && write_side_clock && read_side_clock
    && write_request && !full && !read_request |=> !empty) else $error("single clock empty late");
  c_full_clear: cover property ($fell(full));
  c_empty_clear: cover property ($fell(empty));
  c_overflow: cover property (write_overflow_flag);
  c_underflow: cover property (read_underflow_flag);
endmodule

bind dcff_core dcff_monitor u_mon (.clock(clock), .rst(rst), .write_side_clock(write_side_clock),
  .read_side_clock(read_side_clock), .write_request(write_request), .read_request(read_request),
  .lookahead_mode(lookahead_mode), .single_clock_select(single_clock_select), .empty(empty),
  .nearly_empty_flag(nearly_empty_flag), .read_underflow_flag(read_underflow_flag), .full(full),
  .nearly_full_flag(nearly_full_flag), .write_overflow_flag(write_overflow_flag));

// ### dcff_pkg.sv
// Package holding the shared constants and flag carriers of the flag and mode FIFO.
// Assumes every design file imports it whole; it holds no logic.
// Functional notes
// - Standard mode: read presents oldest word
// - Lookahead: first word appears without read
// - Single-clock mode: flags have no added latency
// - Empty asserts at once, clears after 3/4
// - Full asserts at once, clears after three
// - Nearly flags: latency one set, three clear
// - Clock phase may delay clearing one cycle
// - Pointers freeze when empty or full
// - Nearly-empty hysteresis around threshold, read side
// - Nearly-full hysteresis around threshold, write side
// - Read while empty: pointer holds, underflow flags
// - Write while full: pointer holds, overflow flags
// - Empty clear resynchronised through cascaded flops
// - Both thresholds are thirteen-bit values
// - Lookahead defaults off, falls first word through
// - Output pipeline adds one cycle, single clock
// - Word size from 4/9/18/36/72, default 4
// - Single clock needs lookahead off; default off
// - Reset: empty flags set, full flags cleared
package dcff_pkg;

  // Threshold width and a width one bit wider for compares
  localparam int DCFF_THRESH_W = 13;
  localparam int DCFF_CMP_W    = DCFF_THRESH_W + 1;

  // Default word size and default storage depth
  localparam int DCFF_WORD_DEF  = 4;
  localparam int DCFF_DEPTH_DEF = 16;

  // Read-side flags travel together
  typedef struct packed {
    logic empty;
    logic nearly_empty;
    logic underflow;
  } dcff_rd_flags_t;

  // Write-side flags travel together
  typedef struct packed {
    logic full;
    logic nearly_full;
    logic overflow;
  } dcff_wr_flags_t;

  // Values after reset
  localparam dcff_rd_flags_t DCFF_RD_FLAGS_RST = '{empty: 1'b1, nearly_empty: 1'b1, underflow: 1'b0};
  localparam dcff_wr_flags_t DCFF_WR_FLAGS_RST = '{full: 1'b0, nearly_full: 1'b0, overflow: 1'b0};
  localparam logic           DCFF_VALID_RST    = 1'b0;

endpackage

// ### dcff_store.sv
// Word store of the FIFO: a ring of DEPTH words with valid/ready on both sides.
// Assumes one clock; the read word comes out of a register one cycle after the take.
`timescale 1ns/1ps
module dcff_store
  import dcff_pkg::*;
#(
  parameter int WIDTH = DCFF_WORD_DEF,
  parameter int DEPTH = DCFF_DEPTH_DEF
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Word array
  logic [AW-1:0]    wa_q, wa_d;     // Write slot
  logic [AW-1:0]    ra_q, ra_d;     // Read slot
  logic [AW:0]      cnt_q, cnt_d;   // Words held
  logic [WIDTH-1:0] dout_q;         // Registered read word
  logic             push, pop;

  // Honest full and empty from the held count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = dout_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Next slots and count
  always_comb begin
    wa_d  = wa_q;
    ra_d  = ra_q;
    cnt_d = cnt_q;
    if (push) begin
      wa_d = (wa_q == AW'(DEPTH-1)) ? '0 : wa_q + 1'b1;
    end
    if (pop) begin
      ra_d = (ra_q == AW'(DEPTH-1)) ? '0 : ra_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Slot and count registers
  always_ff @(posedge clock) begin
    if (rst) begin
      wa_q  <= '0;
      ra_q  <= '0;
      cnt_q <= '0;
    end else begin
      wa_q  <= wa_d;
      ra_q  <= ra_d;
      cnt_q <= cnt_d;
    end
  end

  // Array and read register keep contents across reset
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wa_q] <= in_data;
    end
    if (pop) begin
      dout_q <= mem_q[ra_q];
    end
  end

endmodule

// ### dcff_user_model.sv
// Model of the user logic writing and reading words at random tick rates.
// Assumes the bench muxes its requests in only while run is high.
`timescale 1ns/1ps
module dcff_user_model
  import dcff_pkg::*;
#(
  parameter int W = DCFF_WORD_DEF
) (
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  run,
  input  wire logic  empty,
  output logic       wr_tick,
  output logic       rd_tick,
  output logic       wr_req,
  output logic       rd_req,
  output logic [W-1:0] wr_data
);
  // Ticks every clock when idle, unrelated rates when running
  always @(negedge clock) begin
    wr_tick <= !run || ($urandom_range(1) == 0);
    rd_tick <= !run || ($urandom_range(2) == 0);
    wr_req  <= run && !rst && ($urandom_range(1) == 1);
    rd_req  <= run && !rst && !empty && ($urandom_range(1) == 1);
    wr_data <= W'($urandom);
  end
endmodule

// ### testbench.sv
// Self-checking bench of the flag FIFO with a read-order scoreboard.
// Assumes the monitor is bound from its own file.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, s); end end
module testbench
  import dcff_pkg::*;
;
  logic        clock = 1'b1;              // Clock, first edge falling
  logic        rst   = 1'b1;              // Synchronous reset
  logic        run = 0, la = 0, sc = 0, ps = 1; // Traffic and mode selects
  logic        tb_wr = 0, tb_rd = 0;      // Directed requests
  logic [3:0]  tb_wd = '0, m_wd, rdo;     // Words
  logic [12:0] the = 13'h3, thf = 13'h3;  // Thresholds
  logic        wtk, rtk, m_wr, m_rd, wr_rq, rd_rq;
  logic        emp, nemp, udf, ful, nful, ovf;
  logic [3:0]  q[$];                      // Words in flight
  logic [3:0]  pd[3];                     // Read data pipeline
  logic [2:0]  pv;                        // Its valid bits
  int          err_count = 0, n_tests = 0, cyc = 0, n, k;
  assign wr_rq = run ? m_wr : tb_wr;
  assign rd_rq = run ? m_rd : tb_rd;
  always #12.5 clock = ~clock;
  dcff_core dut (.clock(clock), .rst(rst), .write_side_clock(wtk), .read_side_clock(rtk),
    .write_request(wr_rq), .write_data_in(run ? m_wd : tb_wd), .read_request(rd_rq),
    .lookahead_mode(la), .single_clock_select(sc), .output_pipeline_select(ps),
    .nearly_empty_threshold(the), .nearly_full_threshold(thf), .read_data_out(rdo), .empty(emp),
    .nearly_empty_flag(nemp), .read_underflow_flag(udf), .full(ful), .nearly_full_flag(nful),
    .write_overflow_flag(ovf));
  dcff_user_model user (.clock(clock), .rst(rst), .run(run), .empty(emp), .wr_tick(wtk),
    .rd_tick(rtk), .wr_req(m_wr), .rd_req(m_rd), .wr_data(m_wd));
  // Hang guard
  always @(posedge clock) begin
    if (++cyc > 20000) begin
      err_count++;
      wrap_up();
    end
  end
  // Scoreboard: standard reads show their word two edges later, three with the pipeline
  always @(posedge clock) begin
    if (rst) begin
      q.delete();
      pv = '0;
    end else begin
      if ((sc && ps) ? pv[2] : pv[1]) `CHK("read_data_out", (sc && ps) ? pd[2] : pd[1], rdo)
      pd[2] = pd[1];
      pd[1] = pd[0];
      pv = {pv[1:0], rtk && rd_rq && !emp && !la};
      if (pv[0]) pd[0] = q.pop_front();
      if (wtk && wr_rq && !ful) q.push_back(run ? m_wd : tb_wd);
    end
  end
  // Expected nearly flag while moving away from the far end
  function automatic logic near(input int v, input int t);
    return v <= t;
  endfunction
  task wrap_up;
    $display("errors=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task reset_dut(input logic s, input logic l, input logic p);
    sc = s;
    la = l;
    ps = p;
    the = l ? 13'($urandom_range(8, 4)) : 13'($urandom_range(5, 1));
    thf = 13'($urandom_range(5, 1));
    rst = 1;
    repeat (4) @(negedge clock);
    rst = 0;
  endtask
  task wr;
    tb_wr = 1;
    @(negedge clock);
    tb_wr = 0;
  endtask
  task rd;
    tb_rd = 1;
    @(negedge clock);
    tb_rd = 0;
  endtask
  initial begin
    void'($urandom(32'h935e19de));
    reset_dut(0, 0, 1);
    `CHK("reset flags", 6'b110000, {emp, nemp, ful, nful, udf, ovf})
    // Empty release latency in both read modes
    for (k = 0; k < 2; k++) begin
      reset_dut(0, k[0], 1);
      tb_wd = 4'($urandom);
      wr;
      n = 0;
      while (emp && n < 9) begin
        @(negedge clock);
        n++;
      end
      `CHK("empty latency", k ? 4 : 3, n)
      if (k) begin
        // The shown word lands one clock after empty falls
        @(negedge clock);
        `CHK("fall through", tb_wd, rdo)
      end
    end
    // Fill, overflow, full release, drain, underflow: multirate, single, single piped
    for (k = 0; k < 3; k++) begin
      reset_dut(k != 0, 0, k != 1);
      tb_wr = 1;
      for (int i = 1; i <= 16; i++) begin
        tb_wd = 4'($urandom);
        @(negedge clock);
        if (k) `CHK("nearly full", near(16 - i, thf), nful)
      end
      `CHK("full", 1'b1, ful)
      @(negedge clock);
      `CHK("overflow", 1'b1, ovf)
      tb_wr = 0;
      @(negedge clock);
      `CHK("overflow clear", 1'b0, ovf)
      rd;
      n = 0;
      while (ful && n < 9) begin
        @(negedge clock);
        n++;
      end
      `CHK("full latency", k ? 0 : 3, n)
      for (int i = 14; i >= 0; i--) begin
        @(negedge clock);
        rd;
        if (k) `CHK("nearly empty", near(i, the), nemp)
      end
      repeat (4) @(negedge clock);
      `CHK("empty", 1'b1, emp)
      tb_rd = 1;
      repeat (2) @(negedge clock);
      `CHK("underflow", 1'b1, udf)
      tb_rd = 0;
      @(negedge clock);
      `CHK("underflow clear", 1'b0, udf)
    end
    // Random traffic at unrelated tick rates
    reset_dut(0, 0, 1);
    run = 1;
    repeat (3000) @(negedge clock);
    run = 0;
    repeat (8) @(negedge clock);
    wrap_up();
  end
endmodule
